// ---- hw/sdram_pkg.sv ----
package sdram_pkg;
  // ------------------------------------------------------------
  // Command codes on {cs_n, ras_n, cas_n, we_n}
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  // ------------------------------------------------------------
  // Burst mode field encodings
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] MODE_PER_COMMAND = 2'h1;
  localparam logic [1:0] MODE_FIXED_CHOP = 2'h2;
  // ------------------------------------------------------------
  // Burst sizes and reset values
  // ------------------------------------------------------------
  localparam logic [3:0] BEATS_EIGHT = 4'h8;
  localparam logic [3:0] BEATS_CHOP = 4'h4;
  localparam logic [7:0] BANKS_IDLE = 8'h00;
  localparam logic [4:0] LAT_ONE = 5'h01;
  localparam logic [4:0] LAT_ZERO = 5'h00;
  localparam logic [3:0] BEAT_LAST = 4'h1;
  localparam int BANK_BITS = 3;
  localparam int LINK_PERIOD_NS = 160;
  typedef enum logic [1:0] {ST_IDLE, ST_LATENCY, ST_DATA, ST_SELF_REFRESH} dev_state_t;
endpackage

// ---- hw/beat_fifo_if.sv ----
interface beat_fifo_if #(parameter int W = 11);
  logic [W-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [W-1:0] rdata;
  logic rvalid;
  logic rready;
  modport writer (output wdata, output wvalid, input wready);
  modport store (input wdata, input wvalid, output wready,
                 output rdata, output rvalid, input rready);
endinterface

// ---- hw/beat_fifo.sv ----
module beat_fifo #(
  parameter int W = 11,
  parameter int DEPTH = 32
) (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Both sides
  beat_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  if (W < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_param_check
    $error("beat_fifo depth must be a power of two of at least 2");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic do_wr, do_rd, full, empty;
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign f.wready = !full;
  assign f.rvalid = !empty;
  assign f.rdata = mem[rd_ptr_reg[AW-1:0]];
  assign do_wr = ce && f.wvalid && !full;
  assign do_rd = ce && f.rready && !empty;
  always_comb begin
    wr_ptr_next = do_wr ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = do_rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end
  // Storage has no reset; it is only read behind a valid pointer
  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg[AW-1:0]] <= f.wdata;
    end
  end
endmodule

// ---- hw/sdram_write_precharge_selfrefresh.sv ----
// Functional notes
// - Mode 00, or 01 with chop bit high: eight beats
// - Mode 01 with chop bit low: four beats
// - Mode 10: always four beats
// - Precharge: all-bank bit picks one bank or all
// - Precharged bank idle until activated again
// - Refresh with clock enable low enters self-refresh
// - Loop off on entry, on and reset on exit
// - In self-refresh only clock enable is heeded
// - One internal refresh on self-refresh entry
// - Write latency is additive plus column latency
// - Masked beats are discarded, unmasked stored while the buffer is not full
module sdram_write_precharge_selfrefresh #(
  parameter int DW = 8,
  parameter int FIFO_DEPTH = 32
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Device pins
  input wire logic ck_pin,
  input wire logic cke_pin,
  input wire logic cs_n_pin,
  input wire logic ras_n_pin,
  input wire logic cas_n_pin,
  input wire logic we_n_pin,
  input wire logic [sdram_pkg::BANK_BITS-1:0] bank_pin,
  input wire logic all_bank_select_bit,
  input wire logic burst_chop_select_bit,
  input wire logic dqs_pin,
  input wire logic [DW-1:0] dq_pin,
  input wire logic write_data_mask,
  // Configuration
  input wire logic [1:0] burst_mode_field,
  input wire logic [3:0] additive_latency,
  input wire logic [3:0] column_write_latency,
  input wire logic clear_flags,
  // Stored beats: {bank, data}
  output logic [sdram_pkg::BANK_BITS+DW-1:0] beat_data,
  output logic beat_valid,
  input wire logic beat_ready,
  // Status
  output logic [7:0] bank_open,
  output logic self_refresh,
  output logic dll_enabled,
  output logic dll_reset,
  output logic internal_refresh,
  output logic burst_chop,
  output logic write_to_idle_bank,
  output logic write_overrun
);
  // Ten single-bit pins, then bank and data
  localparam int NP = 10 + sdram_pkg::BANK_BITS + DW;
  localparam int FW = sdram_pkg::BANK_BITS + DW;
  if (DW < 1 || FIFO_DEPTH < 2) begin : g_param_check
    $error("data width or fifo depth out of range");
  end
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // All pins share the same two stages, so their mutual alignment holds
  logic [NP-1:0] sync1_reg, sync2_reg;
  logic ck_s, dqs_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, a10_s, a12_s, dm_s;
  logic [sdram_pkg::BANK_BITS-1:0] bank_s;
  logic [DW-1:0] dq_s;
  logic ck_prev_reg, dqs_prev_reg;
  assign {ck_s, dqs_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, a10_s, a12_s, dm_s,
          bank_s, dq_s} = sync2_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      ck_prev_reg <= 1'b0;
      dqs_prev_reg <= 1'b0;
    end else if (ce) begin
      sync1_reg <= {ck_pin, dqs_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin,
                    all_bank_select_bit, burst_chop_select_bit, write_data_mask,
                    bank_pin, dq_pin};
      sync2_reg <= sync1_reg;
      ck_prev_reg <= ck_s;
      dqs_prev_reg <= dqs_s;
    end
  end
  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  sdram_pkg::dev_state_t state_reg, state_next;
  logic link_rise, dqs_edge, dqs_rise, active, cmd_ok;
  logic act_take, write_take, pre_take, sre_take, sr_exit;
  logic [3:0] cmd;
  logic chop_sel;
  logic [4:0] wl;
  assign link_rise = ce && ck_s && !ck_prev_reg;
  assign dqs_edge = ce && (dqs_s ^ dqs_prev_reg);
  assign dqs_rise = dqs_edge && dqs_s;
  assign cmd = {cs_n_s, ras_n_s, cas_n_s, we_n_s};
  assign active = link_rise && (state_reg != sdram_pkg::ST_SELF_REFRESH);
  assign cmd_ok = active && cke_s;
  assign act_take = cmd_ok && cmd == sdram_pkg::CMD_ACTIVATE;
  assign write_take = cmd_ok && cmd == sdram_pkg::CMD_WRITE && state_reg == sdram_pkg::ST_IDLE;
  assign pre_take = cmd_ok && cmd == sdram_pkg::CMD_PRECHARGE;
  assign sre_take = active && !cke_s && cmd == sdram_pkg::CMD_REFRESH &&
                    state_reg == sdram_pkg::ST_IDLE;
  assign sr_exit = link_rise && cke_s && state_reg == sdram_pkg::ST_SELF_REFRESH;
  assign wl = {1'b0, additive_latency} + {1'b0, column_write_latency};
  always_comb begin
    unique case (burst_mode_field)
      sdram_pkg::MODE_PER_COMMAND: chop_sel = !a12_s;
      sdram_pkg::MODE_FIXED_CHOP: chop_sel = 1'b1;
      default: chop_sel = 1'b0;
    endcase
  end
  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  logic [7:0] bank_open_reg, bank_open_next;
  logic [4:0] lat_reg, lat_next;
  logic [3:0] beats_reg, beats_next;
  logic [sdram_pkg::BANK_BITS-1:0] wbank_reg, wbank_next;
  logic first_reg, first_next, chop_reg, chop_next;
  logic dll_reg, dll_next, dll_rst_reg, dll_rst_next, iref_reg, iref_next;
  logic idle_err_reg, idle_err_next, ovr_reg, ovr_next, push;
  logic sr_reg, sr_next;
  beat_fifo_if #(.W(FW)) fifo_bus ();
  always_comb begin
    state_next = state_reg;
    bank_open_next = bank_open_reg;
    lat_next = lat_reg;
    beats_next = beats_reg;
    wbank_next = wbank_reg;
    first_next = first_reg;
    chop_next = chop_reg;
    dll_next = dll_reg;
    dll_rst_next = 1'b0;
    iref_next = 1'b0;
    push = 1'b0;
    if (act_take) begin
      bank_open_next[bank_s] = 1'b1;
    end
    if (pre_take) begin
      if (a10_s) begin
        bank_open_next = sdram_pkg::BANKS_IDLE;
      end else begin
        bank_open_next[bank_s] = 1'b0;
      end
    end
    unique case (state_reg)
      sdram_pkg::ST_IDLE: begin
        if (write_take) begin
          chop_next = chop_sel;
          beats_next = chop_sel ? sdram_pkg::BEATS_CHOP : sdram_pkg::BEATS_EIGHT;
          wbank_next = bank_s;
          lat_next = wl;
          first_next = 1'b0;
          state_next = (wl == sdram_pkg::LAT_ZERO) ? sdram_pkg::ST_DATA :
                                                    sdram_pkg::ST_LATENCY;
        end else if (sre_take) begin
          state_next = sdram_pkg::ST_SELF_REFRESH;
          dll_next = 1'b0;
          iref_next = 1'b1;
        end
      end
      sdram_pkg::ST_LATENCY: begin
        if (link_rise) begin
          lat_next = lat_reg - sdram_pkg::LAT_ONE;
          if (lat_reg == sdram_pkg::LAT_ONE) begin
            state_next = sdram_pkg::ST_DATA;
          end
        end
      end
      sdram_pkg::ST_DATA: begin
        // First beat waits for the rising strobe edge after the preamble
        if (dqs_edge && (first_reg || dqs_rise)) begin
          first_next = 1'b1;
          push = !dm_s;
          beats_next = beats_reg - 4'h1;
          if (beats_reg == sdram_pkg::BEAT_LAST) begin
            state_next = sdram_pkg::ST_IDLE;
          end
        end
      end
      sdram_pkg::ST_SELF_REFRESH: begin
        if (sr_exit) begin
          state_next = sdram_pkg::ST_IDLE;
          dll_next = 1'b1;
          dll_rst_next = 1'b1;
        end
      end
    endcase
    // Sticky flags: a new event wins over a clear in the same cycle
    idle_err_next = (idle_err_reg && !clear_flags) ||
                    (write_take && !bank_open_reg[bank_s]);
    ovr_next = (ovr_reg && !clear_flags) || (push && !fifo_bus.wready);
    sr_next = (state_next == sdram_pkg::ST_SELF_REFRESH);
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= sdram_pkg::ST_IDLE;
      bank_open_reg <= sdram_pkg::BANKS_IDLE;
      lat_reg <= sdram_pkg::LAT_ZERO;
      beats_reg <= sdram_pkg::BEATS_EIGHT;
      wbank_reg <= '0;
      first_reg <= 1'b0;
      chop_reg <= 1'b0;
      dll_reg <= 1'b1;
      dll_rst_reg <= 1'b0;
      iref_reg <= 1'b0;
      idle_err_reg <= 1'b0;
      ovr_reg <= 1'b0;
      sr_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      bank_open_reg <= bank_open_next;
      lat_reg <= lat_next;
      beats_reg <= beats_next;
      wbank_reg <= wbank_next;
      first_reg <= first_next;
      chop_reg <= chop_next;
      dll_reg <= dll_next;
      dll_rst_reg <= dll_rst_next;
      iref_reg <= iref_next;
      idle_err_reg <= idle_err_next;
      ovr_reg <= ovr_next;
      sr_reg <= sr_next;
    end
  end
  // ------------------------------------------------------------
  // Beat buffer
  // ------------------------------------------------------------
  // A strobe cannot be stalled, so a full buffer drops the beat and flags it
  assign fifo_bus.wdata = {wbank_reg, dq_s};
  assign fifo_bus.wvalid = push;
  assign fifo_bus.rready = beat_ready;
  beat_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .f(fifo_bus)
  );
  assign beat_data = fifo_bus.rdata;
  assign beat_valid = fifo_bus.rvalid;
  assign bank_open = bank_open_reg;
  assign self_refresh = sr_reg;
  assign dll_enabled = dll_reg;
  assign dll_reset = dll_rst_reg;
  assign internal_refresh = iref_reg;
  assign burst_chop = chop_reg;
  assign write_to_idle_bank = idle_err_reg;
  assign write_overrun = ovr_reg;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_eight_cmd;
    write_take && (burst_mode_field == sdram_pkg::MODE_FIXED_EIGHT ||
                   (burst_mode_field == sdram_pkg::MODE_PER_COMMAND && a12_s));
  endsequence
  sequence s_enter;
    sre_take ##1 self_refresh;
  endsequence
  property p_eight;
    s_eight_cmd |=> !chop_reg && beats_reg == sdram_pkg::BEATS_EIGHT;
  endproperty
  a_eight: assert property (p_eight) else $error("eight-beat burst not chosen");
  property p_chop_otf;
    write_take && burst_mode_field == sdram_pkg::MODE_PER_COMMAND && !a12_s
      |=> chop_reg && beats_reg == sdram_pkg::BEATS_CHOP;
  endproperty
  a_chop_otf: assert property (p_chop_otf) else $error("chop not chosen");
  property p_chop_fixed;
    write_take && burst_mode_field == sdram_pkg::MODE_FIXED_CHOP |=> chop_reg;
  endproperty
  a_chop_fixed: assert property (p_chop_fixed) else $error("fixed chop ignored");
  property p_pre_all;
    pre_take && a10_s |=> bank_open_reg == sdram_pkg::BANKS_IDLE;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("banks left open");
  property p_pre_one;
    pre_take && !a10_s && !act_take |=> !bank_open_reg[$past(bank_s)];
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("bank left open");
  property p_sr_entry;
    s_enter |-> !dll_reg && iref_reg ##1 (!iref_reg || !$past(ce));
  endproperty
  a_sr_entry: assert property (p_sr_entry) else $error("entry effects wrong");
  property p_dll;
    self_refresh |-> !dll_enabled;
  endproperty
  a_dll: assert property (p_dll) else $error("loop on in self-refresh");
  property p_exit;
    sr_exit |=> !self_refresh && dll_reg && dll_rst_reg;
  endproperty
  a_exit: assert property (p_exit) else $error("exit effects missing");
  property p_hold;
    self_refresh && !sr_exit |=> self_refresh && $stable(bank_open_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("input heeded in self-refresh");
  property p_refresh;
    $rose(self_refresh) |-> internal_refresh;
  endproperty
  a_refresh: assert property (p_refresh) else $error("no internal refresh");
  property p_mask;
    fifo_bus.wvalid |-> !dm_s && state_reg == sdram_pkg::ST_DATA;
  endproperty
  a_mask: assert property (p_mask) else $error("masked beat stored");
  property p_latency;
    write_take && wl == 5'h05 |=> state_reg != sdram_pkg::ST_DATA [*8];
  endproperty
  a_latency: assert property (p_latency) else $error("data before latency");
endmodule

// ---- dv/ctrl_model.sv ----
module ctrl_model (
  // Bench clock
  input wire logic sys_clk,
  // Command pins
  output logic ck_pin,
  output logic cke_pin,
  output logic cs_n_pin,
  output logic ras_n_pin,
  output logic cas_n_pin,
  output logic we_n_pin,
  output logic [2:0] bank_pin,
  output logic all_bank_select_bit,
  output logic burst_chop_select_bit,
  // Write data pins
  output logic dqs_pin,
  output logic [7:0] dq_pin,
  output logic write_data_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Controller side: clock runs only while a task of this model (send, burst or q) is called
  // ------------------------------------------------------------
  logic ph = 1'b0;
  initial begin
    {ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = 6'h18;
    {bank_pin, all_bank_select_bit, burst_chop_select_bit} = 5'h00;
    {dqs_pin, dq_pin, write_data_mask} = 10'h200;
  end
  // Quarter of a device clock; ck toggles every second quarter
  task automatic q();
    repeat (8) @(posedge sys_clk);
    ph = ~ph;
    if (!ph) ck_pin <= ~ck_pin;
  endtask
  // Pins are set while ck is low and released a quarter after the rise,
  // so the rise sees settled levels and back-to-back calls never collide
  task automatic send(input logic cke, input logic [3:0] code, input logic [2:0] bank,
                      input logic a10, input logic a12);
    cke_pin <= cke;
    {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} <= code;
    bank_pin <= bank;
    all_bank_select_bit <= a10;
    burst_chop_select_bit <= a12;
    repeat (3) q();
    {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} <= 4'h8;
    bank_pin <= ~bank;
    q();
  endtask
  task automatic burst(input logic [2:0] bank, input logic a12, input int wl, input int beats,
                       input logic [63:0] data, input logic [7:0] mask);
    dqs_pin <= 1'b1;
    send(1'b1, sdram_pkg::CMD_WRITE, bank, 1'b0, a12);
    repeat (4 * wl) q();
    dqs_pin <= 1'b0;
    repeat (2) q();
    for (int i = 0; i < beats; i++) begin
      dq_pin <= data[8*i+:8];
      write_data_mask <= mask[i];
      q();
      dqs_pin <= ~dqs_pin;
      q();
    end
    repeat (2) q();
    // Released lines show the inverse so a stale value cannot pass
    dqs_pin <= 1'b1;
    dq_pin <= ~dq_pin;
    write_data_mask <= ~write_data_mask;
    repeat (8) q();
  endtask
endmodule

// ---- dv/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic clear_flags = 1'b0;
  logic beat_ready = 1'b0;
  logic stall = 1'b0;
  logic sr_d = 1'b0;
  logic [1:0] burst_mode_field = 2'h0;
  logic [3:0] additive_latency = 4'h0;
  logic [3:0] column_write_latency = 4'h5;
  logic [7:0] lfsr_reg = 8'h26;
  logic ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin;
  logic all_bank_select_bit, burst_chop_select_bit, dqs_pin, write_data_mask;
  logic [2:0] bank_pin;
  logic [7:0] dq_pin, bank_open;
  logic [10:0] beat_data;
  logic beat_valid, self_refresh, dll_enabled, dll_reset, internal_refresh;
  logic burst_chop, write_to_idle_bank, write_overrun;
  logic [10:0] exp_q[$];
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  int kept = 0;
  // ------------------------------------------------------------
  // Clock, models and device
  // ------------------------------------------------------------
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  ctrl_model i_ctrl (.sys_clk(sys_clk), .ck_pin(ck_pin), .cke_pin(cke_pin),
    .cs_n_pin(cs_n_pin), .ras_n_pin(ras_n_pin), .cas_n_pin(cas_n_pin), .we_n_pin(we_n_pin),
    .bank_pin(bank_pin), .all_bank_select_bit(all_bank_select_bit),
    .burst_chop_select_bit(burst_chop_select_bit), .dqs_pin(dqs_pin), .dq_pin(dq_pin),
    .write_data_mask(write_data_mask));
  sdram_write_precharge_selfrefresh #(.DW(8), .FIFO_DEPTH(32)) i_dut (.sys_clk(sys_clk),
    .rst(rst), .ce(ce), .ck_pin(ck_pin), .cke_pin(cke_pin), .cs_n_pin(cs_n_pin),
    .ras_n_pin(ras_n_pin), .cas_n_pin(cas_n_pin), .we_n_pin(we_n_pin), .bank_pin(bank_pin),
    .all_bank_select_bit(all_bank_select_bit), .burst_chop_select_bit(burst_chop_select_bit),
    .dqs_pin(dqs_pin), .dq_pin(dq_pin), .write_data_mask(write_data_mask),
    .burst_mode_field(burst_mode_field), .additive_latency(additive_latency),
    .column_write_latency(column_write_latency), .clear_flags(clear_flags),
    .beat_data(beat_data), .beat_valid(beat_valid), .beat_ready(beat_ready),
    .bank_open(bank_open), .self_refresh(self_refresh), .dll_enabled(dll_enabled),
    .dll_reset(dll_reset), .internal_refresh(internal_refresh), .burst_chop(burst_chop),
    .write_to_idle_bank(write_to_idle_bank), .write_overrun(write_overrun));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Counts: compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Notes the stored beats, then lets the controller model send the burst
  task automatic wr(input logic [1:0] mode, input logic [2:0] bank, input logic a12,
                    input logic [7:0] mask);
    logic [63:0] d;
    logic [7:0] x;
    int beats;
    int wl;
    x = lfsr_reg;
    for (int i = 0; i < 8; i++) begin
      x = lfsr_next(x);
      d[8*i+:8] = x;
    end
    beats = (mode == sdram_pkg::MODE_FIXED_CHOP || (mode == sdram_pkg::MODE_PER_COMMAND && !a12))
      ? 4 : 8;
    wl = int'(x[1:0]) + 5 + int'(x[2]);
    additive_latency <= {2'h0, x[1:0]};
    column_write_latency <= 4'h5 + {3'h0, x[2]};
    burst_mode_field <= mode;
    for (int i = 0; i < beats; i++) begin
      if (!mask[i] && (!stall || kept < 32)) begin
        exp_q.push_back({bank, d[8*i+:8]});
        kept++;
      end
    end
    i_ctrl.burst(bank, a12, wl, beats, d, mask);
    check({10'h000, burst_chop}, {10'h000, beats == 4});
  endtask
  task automatic drain();
    for (int i = 0; i < 2000 && exp_q.size() != 0; i++) @(posedge sys_clk);
  endtask
  // ------------------------------------------------------------
  // Stimulus, watchers and timeout
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    lfsr_reg <= lfsr_next(lfsr_reg);
    beat_ready <= !stall && lfsr_reg[0];
    // Enable drops for single cycles only, so two-cycle level pulses still land
    ce <= !ce || lfsr_reg[3:0] != 4'hF;
    sr_d <= self_refresh;
    cycles <= cycles + 1;
    if (beat_valid === 1'b1 && beat_ready === 1'b1 && ce === 1'b1) begin
      if (exp_q.size() == 0) check(beat_data, 11'h7FF);
      else check(beat_data, exp_q.pop_front());
    end
    if (self_refresh === 1'b1 && sr_d === 1'b0)
      check({internal_refresh, dll_enabled}, 11'h002);
    if (self_refresh === 1'b0 && sr_d === 1'b1) check({dll_reset, dll_enabled}, 11'h003);
    if (cycles == 30000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check({bank_open, self_refresh, dll_enabled, beat_valid}, 11'h002);
    $display("Test reset done");
    for (int b = 0; b < 8; b++) i_ctrl.send(1'b1, sdram_pkg::CMD_ACTIVATE, 3'(b), 1'b0, 1'b0);
    check({3'h0, bank_open}, 11'h0FF);
    i_ctrl.send(1'b1, sdram_pkg::CMD_PRECHARGE, 3'h3, 1'b0, 1'b0);
    check({3'h0, bank_open}, 11'h0F7);
    $display("Test bank open and single precharge done");
    for (int i = 0; i < 5; i++) wr(2'(i - (i > 1)), 3'(4 + i), i[0], lfsr_reg & 8'h49);
    check({10'h000, write_to_idle_bank}, 11'h000);
    $display("Test burst modes done");
    i_ctrl.send(1'b1, sdram_pkg::CMD_PRECHARGE, 3'h5, 1'b1, 1'b0);
    check({3'h0, bank_open}, 11'h000);
    wr(sdram_pkg::MODE_FIXED_EIGHT, 3'h2, 1'b0, 8'h00);
    check({10'h000, write_to_idle_bank}, 11'h001);
    clear_flags <= 1'b1;
    repeat (2) @(posedge sys_clk);
    clear_flags <= 1'b0;
    @(posedge sys_clk);
    check({10'h000, write_to_idle_bank}, 11'h000);
    drain();
    $display("Test all-bank precharge and idle-bank write done");
    stall <= 1'b1;
    kept = 0;
    for (int i = 0; i < 5; i++) wr(sdram_pkg::MODE_FIXED_EIGHT, 3'(i), 1'b1, 8'h00);
    check({10'h000, write_overrun}, 11'h001);
    stall <= 1'b0;
    drain();
    repeat (8) @(posedge sys_clk);
    check({10'h000, beat_valid}, 11'h000);
    $display("Test buffer full and drain done");
    i_ctrl.send(1'b0, sdram_pkg::CMD_REFRESH, 3'h0, 1'b0, 1'b0);
    check({10'h000, self_refresh}, 11'h001);
    i_ctrl.send(1'b0, sdram_pkg::CMD_ACTIVATE, 3'h1, 1'b0, 1'b0);
    check({2'h0, bank_open, self_refresh}, 11'h001);
    repeat (8) i_ctrl.q();
    i_ctrl.send(1'b1, 4'h7, 3'h0, 1'b0, 1'b0);
    i_ctrl.send(1'b1, 4'h7, 3'h0, 1'b0, 1'b0);
    check({9'h000, self_refresh, dll_enabled}, 11'h001);
    $display("Test self-refresh entry and exit done");
    check(11'(exp_q.size()), 11'h000);
    print_verdict();
  end
endmodule
